//--- design/ctd_control.v
`include "ctd_map.vh"
`default_nettype none

module ctd_control (
   input  wire        clock,
   input  wire        rst,
   input  wire        word_strobe,
   input  wire [15:0] word_data,
   input  wire        word_mode,
   output reg         secondary_expected,
   output reg  [13:0] dac_data,
   output wire        hp_filter_in,
   output wire        loopback,
   output wire        aux_enable,
   output wire        sync_mode,
   output wire [1:0]  gain,
   output wire        droop_filter_in,
   output wire        user_out_bit_ten,
   output wire        user_out_bit_eleven,
   output wire        tx_conv,
   output wire        rx_conv,
   output wire        shutdown,
   output wire        port_halted
);
   reg  [4:0]  tx_divider_a;
   reg  [5:0]  tx_period_trim;
   reg  [5:0]  tx_divider_b;
   reg  [4:0]  rx_divider_a;
   reg  [5:0]  rx_period_trim;
   reg  [5:0]  rx_divider_b;
   reg  [15:0] configuration_word;
   reg         tx_adj_pend;
   reg         tx_adj_sub;
   reg         rx_adj_pend;
   reg         rx_adj_sub;
   reg         rx_locked;

   wire        accept   = word_strobe & ~port_halted & ~shutdown;
   wire        take_sec = accept & secondary_expected;
   wire        take_pri = accept & ~secondary_expected;
   wire [1:0]  sel      = word_data[`CTD_SEL_LSB:0];
   wire        adj_cmd  = take_pri & ((sel == `CTD_PRI_ADD) | (sel == `CTD_PRI_SUB));
   wire        cmd_sub  = (sel == `CTD_PRI_SUB);
   wire        rx_open  = sync_mode | ~rx_locked;
   wire        rx_write = take_sec & (sel != `CTD_SEL_CONFIG) & rx_open;
   wire        tx_taken;
   wire        rx_taken;

   wire [5:0]  new_tx_b = word_data[`CTD_TX6_MSB:`CTD_TX6_LSB];
   wire [5:0]  new_rx_b = word_data[`CTD_RX6_MSB:`CTD_RX6_LSB];

   // Receive timing follows the transmit set when synchronous
   wire [4:0]  rx_a_use    = sync_mode ? tx_divider_a   : rx_divider_a;
   wire [5:0]  rx_trim_use = sync_mode ? tx_period_trim : rx_period_trim;
   wire [5:0]  rx_b_use    = sync_mode ? tx_divider_b   : rx_divider_b;
   wire        rx_adj_use  = sync_mode ? tx_adj_pend    : rx_adj_pend;
   wire        rx_sub_use  = sync_mode ? tx_adj_sub     : rx_adj_sub;

   assign hp_filter_in        = configuration_word[`CTD_CFG_HPF];
   assign loopback            = configuration_word[`CTD_CFG_LOOP];
   assign aux_enable          = configuration_word[`CTD_CFG_AUX];
   assign sync_mode           = configuration_word[`CTD_CFG_SYNC];
   assign gain                = configuration_word[`CTD_CFG_GAIN_MSB:`CTD_CFG_GAIN_LSB];
   assign droop_filter_in     = configuration_word[`CTD_CFG_DROOP];
   assign user_out_bit_ten    = configuration_word[`CTD_CFG_OUT10];
   assign user_out_bit_eleven = configuration_word[`CTD_CFG_OUT11];

   // Frame sequencing: a primary ending in 11 reserves the next word
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         secondary_expected <= 1'h0;
      end else if (take_pri & (sel == `CTD_PRI_SECONDARY)) begin
         secondary_expected <= 1'h1;
      end else if (take_sec) begin
         secondary_expected <= 1'h0;
      end
   end

   // Sample register only moves on an accepted primary word, so a stalled
   // link leaves the converter at its last code.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         dac_data <= 14'h0000;
      end else if (take_pri) begin
         dac_data <= word_data[`CTD_DAC_MSB:`CTD_DAC_LSB];
      end
   end

   // Transmit side and configuration are written straight into the live
   // registers, so all but divider B (loaded only at a period start) take effect in the period already running.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_divider_a       <= `CTD_DIVA_RST;
         tx_period_trim     <= `CTD_TRIM_RST;
         tx_divider_b       <= `CTD_DIVB_RST;
         configuration_word <= `CTD_CFG_RST;
      end else if (take_sec) begin
         case (sel)
            `CTD_SEL_DIV_A: begin
               tx_divider_a <= word_data[`CTD_TXA_MSB:`CTD_TXA_LSB];
            end
            `CTD_SEL_TRIM: begin
               tx_period_trim <= word_data[`CTD_TX6_MSB:`CTD_TX6_LSB];
            end
            `CTD_SEL_DIV_B: begin
               tx_divider_b <= (new_tx_b < `CTD_B_MIN) ? `CTD_B_FIX : new_tx_b;
            end
            `CTD_SEL_CONFIG: begin
               configuration_word <= word_data & `CTD_CFG_MASK;
            end
            default: begin
               configuration_word <= configuration_word;
            end
         endcase
      end
   end

   // Receive registers; in asynchronous mode only one set per receive period
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_divider_a   <= `CTD_DIVA_RST;
         rx_period_trim <= `CTD_TRIM_RST;
         rx_divider_b   <= `CTD_DIVB_RST;
      end else if (rx_write) begin
         case (sel)
            `CTD_SEL_DIV_A: begin
               rx_divider_a <= word_data[`CTD_RXA_MSB:`CTD_RXA_LSB];
            end
            `CTD_SEL_TRIM: begin
               rx_period_trim <= word_data[`CTD_RX6_MSB:`CTD_RX6_LSB];
            end
            `CTD_SEL_DIV_B: begin
               rx_divider_b <= (new_rx_b < `CTD_B_MIN) ? `CTD_B_FIX : new_rx_b;
            end
            default: begin
               rx_divider_b <= rx_divider_b;
            end
         endcase
      end
   end

   // A write at the period boundary belongs to the new period: set wins
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_locked <= 1'h0;
      end else if (rx_write & ~sync_mode) begin
         rx_locked <= 1'h1;
      end else if (rx_conv | sync_mode) begin
         rx_locked <= 1'h0;
      end
   end

   // Transmit adjustment waits for the end of the ongoing period, once
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_adj_pend <= 1'h0;
         tx_adj_sub  <= 1'h0;
      end else if (adj_cmd) begin
         tx_adj_pend <= 1'h1;
         tx_adj_sub  <= cmd_sub;
      end else if (tx_taken) begin
         tx_adj_pend <= 1'h0;
      end
   end

   // A receive adjustment that is still waiting already owns the next
   // period that time allows, so a second command is dropped.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_adj_pend <= 1'h0;
         rx_adj_sub  <= 1'h0;
      end else if (adj_cmd & ~sync_mode & (~rx_adj_pend | rx_taken)) begin
         rx_adj_pend <= 1'h1;
         rx_adj_sub  <= cmd_sub;
      end else if (rx_taken | sync_mode) begin
         rx_adj_pend <= 1'h0;
      end
   end

   ctd_period_gen u_tx_gen (
      .clock     (clock),
      .rst       (rst),
      .run       (~shutdown),
      .div_a     (tx_divider_a),
      .trim      (tx_period_trim),
      .div_b     (tx_divider_b),
      .adj_valid (tx_adj_pend),
      .adj_sub   (tx_adj_sub),
      .adj_taken (tx_taken),
      .conv      (tx_conv)
   );

   ctd_period_gen u_rx_gen (
      .clock     (clock),
      .rst       (rst),
      .run       (~shutdown),
      .div_a     (rx_a_use),
      .trim      (rx_trim_use),
      .div_b     (rx_b_use),
      .adj_valid (rx_adj_use),
      .adj_sub   (rx_sub_use),
      .adj_taken (rx_taken),
      .conv      (rx_conv)
   );

   ctd_guard u_guard (
      .clock       (clock),
      .rst         (rst),
      .word_mode   (word_mode),
      .tx_a        (tx_divider_a),
      .rx_a        (rx_a_use),
      .shutdown    (shutdown),
      .port_halted (port_halted)
   );
endmodule // ctd_control

`default_nettype wire

//--- design/ctd_guard.v
`include "ctd_map.vh"
`default_nettype none

// Sticky fault latches; only a reset clears them, as no word is accepted
// afterwards that could reprogram the dividers.
module ctd_guard (
   input  wire       clock,
   input  wire       rst,
   input  wire       word_mode,
   input  wire [4:0] tx_a,
   input  wire [4:0] rx_a,
   output reg        shutdown,
   output reg        port_halted
);
   wire [4:0] a_min = word_mode ? `CTD_A_MIN_WORD : `CTD_A_MIN_BYTE;
   wire       dead  = (tx_a <= `CTD_A_DEAD) | (rx_a <= `CTD_A_DEAD);
   wire       slow  = (tx_a < a_min) | (rx_a < a_min);

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         shutdown    <= 1'h0;
         port_halted <= 1'h0;
      end else begin
         if (dead) begin
            shutdown <= 1'h1;
         end
         if (slow) begin
            port_halted <= 1'h1;
         end
      end
   end
endmodule // ctd_guard

`default_nettype wire

//--- design/ctd_map.vh
`ifndef CTD_MAP_VH
`define CTD_MAP_VH

// Low two bits of a word select its meaning
`define CTD_SEL_LSB        1
`define CTD_SEL_DIV_A      2'h0
`define CTD_SEL_TRIM       2'h1
`define CTD_SEL_DIV_B      2'h2
`define CTD_SEL_CONFIG     2'h3

// Primary word commands
`define CTD_PRI_PLAIN      2'h0
`define CTD_PRI_ADD        2'h1
`define CTD_PRI_SUB        2'h2
`define CTD_PRI_SECONDARY  2'h3

// Primary sample field
`define CTD_DAC_MSB        15
`define CTD_DAC_LSB        2

// Secondary field positions
`define CTD_TXA_MSB        13
`define CTD_TXA_LSB        9
`define CTD_RXA_MSB        6
`define CTD_RXA_LSB        2
`define CTD_TX6_MSB        14
`define CTD_TX6_LSB        9
`define CTD_RX6_MSB        7
`define CTD_RX6_LSB        2

// Configuration bit positions
`define CTD_CFG_HPF        2
`define CTD_CFG_LOOP       3
`define CTD_CFG_AUX        4
`define CTD_CFG_SYNC       5
`define CTD_CFG_GAIN_LSB   6
`define CTD_CFG_GAIN_MSB   7
`define CTD_CFG_DROOP      9
`define CTD_CFG_OUT10      10
`define CTD_CFG_OUT11      11
`define CTD_CFG_MASK       16'h0EFC

// Reset values
`define CTD_DIVA_RST       5'h12
`define CTD_DIVB_RST       6'h12
`define CTD_TRIM_RST       6'h01
`define CTD_CFG_RST        16'h02E4

// Limits and fixed responses
`define CTD_A_DEAD         5'h01
`define CTD_A_MIN_WORD     5'h04
`define CTD_A_MIN_BYTE     5'h05
`define CTD_B_MIN          6'h0F
`define CTD_B_FIX          6'h12
`define CTD_MOD64          7'h40

`endif

//--- design/ctd_period_gen.v
`include "ctd_map.vh"
`default_nettype none

// One conversion period is div_b segments of div_a master clocks each.
// A pending adjustment changes only the final segment of the period.
module ctd_period_gen (
   input  wire       clock,
   input  wire       rst,
   input  wire       run,
   input  wire [4:0] div_a,
   input  wire [5:0] trim,
   input  wire [5:0] div_b,
   input  wire       adj_valid,
   input  wire       adj_sub,
   output wire       adj_taken,
   output reg        conv
);
   reg  [5:0] a_cnt;
   reg  [5:0] b_cnt;
   reg  [5:0] next_a_load;
   reg  [6:0] wrapped;
   wire [6:0] a_ext   = {2'h0, div_a};
   wire [6:0] t_ext   = {trim[5], trim};
   wire [6:0] sum     = adj_sub ? (a_ext - t_ext) : (a_ext + t_ext);
   wire       seg_end = (a_cnt <= 6'h01);
   wire       per_end = run & seg_end & (b_cnt <= 6'h01);

   assign adj_taken = run & seg_end & (b_cnt == 6'h02) & adj_valid;

   always @* begin
      wrapped     = sum + `CTD_MOD64;
      next_a_load = {1'h0, div_a};
      if (adj_valid) begin
         if (sum[6]) begin
            next_a_load = wrapped[5:0];
         end else if (sum <= 7'h01) begin
            next_a_load = {1'h0, div_a};
         end else begin
            next_a_load = sum[5:0];
         end
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         a_cnt <= 6'h00;
         b_cnt <= 6'h00;
         conv  <= 1'h0;
      end else begin
         conv <= per_end;
         if (!run) begin
            a_cnt <= 6'h00;
            b_cnt <= 6'h00;
         end else if (seg_end) begin
            if (b_cnt <= 6'h01) begin
               b_cnt <= div_b;
               a_cnt <= {1'h0, div_a};
            end else begin
               b_cnt <= b_cnt - 6'h01;
               a_cnt <= (b_cnt == 6'h02) ? next_a_load : {1'h0, div_a};
            end
         end else begin
            a_cnt <= a_cnt - 6'h01;
         end
      end
   end
endmodule // ctd_period_gen

`default_nettype wire

//--- tb/ctd_control_asserts.sv
`default_nettype none
module ctd_control_asserts (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        word_strobe,
   input wire logic [15:0] word_data,
   input wire logic        word_mode,
   input wire logic        secondary_expected,
   input wire logic [13:0] dac_data,
   input wire logic        hp_filter_in,
   input wire logic        loopback,
   input wire logic        aux_enable,
   input wire logic        sync_mode,
   input wire logic [1:0]  gain,
   input wire logic        droop_filter_in,
   input wire logic        user_out_bit_ten,
   input wire logic        user_out_bit_eleven,
   input wire logic        shutdown,
   input wire logic        port_halted
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_take;
      word_strobe && !shutdown && !port_halted;
   endsequence
   sequence s_cfg;
      s_take ##0 secondary_expected && word_data[1:0] == 2'h3;
   endsequence
   sequence s_diva;
      s_take ##0 secondary_expected && word_data[1:0] == 2'h0;
   endsequence
   property p_sec_set;
      s_take ##0 !secondary_expected && word_data[1:0] == 2'h3 |=> secondary_expected;
   endproperty
   property p_sec_clr;
      s_take ##0 secondary_expected |=> !secondary_expected;
   endproperty
   property p_cfg_a;
      s_cfg |=> {aux_enable, loopback, hp_filter_in} == $past(word_data[4:2]);
   endproperty
   property p_cfg_b;
      s_cfg |=> {gain, sync_mode} == $past(word_data[7:5]);
   endproperty
   property p_cfg_c;
      s_cfg |=> {user_out_bit_eleven, user_out_bit_ten, droop_filter_in} == $past(word_data[11:9]);
   endproperty
   property p_dac_hold;
      !word_strobe |=> $stable(dac_data);
   endproperty
   property p_shut;
      s_diva ##0 word_data[13:10] == 4'h0 |-> ##[1:3] shutdown ##1 shutdown[*4];
   endproperty
   property p_halt;
      s_diva ##0 word_mode && word_data[13:9] < 5'h04 |-> ##[1:3] port_halted;
   endproperty
   property p_refuse;
      word_strobe && (shutdown || port_halted) |=> $stable(dac_data) && $stable(secondary_expected);
   endproperty
   a_sec_set: assert property (p_sec_set) else $error("flag not set");
   a_sec_clr: assert property (p_sec_clr) else $error("flag not cleared");
   a_cfg_a: assert property (p_cfg_a) else $error("config low bits");
   a_cfg_b: assert property (p_cfg_b) else $error("config sync or gain");
   a_cfg_c: assert property (p_cfg_c) else $error("config high bits");
   a_dac_hold: assert property (p_dac_hold) else $error("output moved");
   a_shut: assert property (p_shut) else $error("no shutdown");
   a_halt: assert property (p_halt) else $error("port not halted");
   a_refuse: assert property (p_refuse) else $error("word taken while halted");
endmodule // ctd_control_asserts
bind ctd_control ctd_control_asserts u_asserts (
   .clock(clock), .rst(rst), .word_strobe(word_strobe), .word_data(word_data),
   .word_mode(word_mode), .secondary_expected(secondary_expected), .dac_data(dac_data),
   .hp_filter_in(hp_filter_in), .loopback(loopback), .aux_enable(aux_enable),
   .sync_mode(sync_mode), .gain(gain), .droop_filter_in(droop_filter_in),
   .user_out_bit_ten(user_out_bit_ten), .user_out_bit_eleven(user_out_bit_eleven),
   .shutdown(shutdown), .port_halted(port_halted)
);
`default_nettype wire

//--- tb/ctd_host_model.sv
`default_nettype none
module ctd_host_model (
   input  wire logic        clock,
   output var  logic        word_strobe,
   output var  logic [15:0] word_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      word_strobe = 1'b0;
      word_data = 16'hA5A5;
   end
   // A released bus shows the inverse, so a stale word never looks valid
   task automatic send(input logic [15:0] d);
      @(posedge clock);
      word_strobe <= 1'b1;
      word_data <= d;
      @(posedge clock);
      word_strobe <= 1'b0;
      word_data <= ~d;
   endtask
   task automatic burst(input logic [15:0] p, input logic [15:0] s);
      @(posedge clock);
      word_strobe <= 1'b1;
      word_data <= p | 16'h0003;
      @(posedge clock);
      word_data <= s;
      @(posedge clock);
      word_strobe <= 1'b0;
      word_data <= ~s;
   endtask
endmodule // ctd_host_model
`default_nettype wire

//--- tb/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        word_mode = 1'b1;
   logic [15:0] w;
   wire         word_strobe, secondary_expected, hp_filter_in, loopback, aux_enable;
   wire         sync_mode, droop_filter_in, user_out_bit_ten, user_out_bit_eleven;
   wire         tx_conv, rx_conv, shutdown, port_halted;
   wire  [15:0] word_data;
   wire  [13:0] dac_data;
   wire  [1:0]  gain;
   wire  [8:0]  cfg_out = {user_out_bit_eleven, user_out_bit_ten, droop_filter_in, gain,
                           sync_mode, aux_enable, loopback, hp_filter_in};
   wire  [1:0]  conv = {rx_conv, tx_conv};
   int          err_total = 0, n_checks = 0, cyc = 0, rx_mis = 0;
   int          t_last[2], gap[2], cnt[2];
   int          tv[4] = '{3, -7, -12, 3};
   int          op[4] = '{1, 1, 1, 2};
   int          ga[4] = '{3, 4, 1, 5};
   logic [3:0]  gm = 4'h5;
   logic [1:0]  gx[4] = '{2'h1, 2'h1, 2'h3, 2'h0};

   always #5 clock = ~clock;
   ctd_host_model host (.clock(clock), .word_strobe(word_strobe), .word_data(word_data));
   ctd_control dut (
      .clock(clock), .rst(rst), .word_strobe(word_strobe), .word_data(word_data),
      .word_mode(word_mode), .secondary_expected(secondary_expected), .dac_data(dac_data),
      .hp_filter_in(hp_filter_in), .loopback(loopback), .aux_enable(aux_enable),
      .sync_mode(sync_mode), .gain(gain), .droop_filter_in(droop_filter_in),
      .user_out_bit_ten(user_out_bit_ten), .user_out_bit_eleven(user_out_bit_eleven),
      .tx_conv(tx_conv), .rx_conv(rx_conv), .shutdown(shutdown), .port_halted(port_halted)
   );

   // Spacing of conversion pulses, in master clocks
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (sync_mode === 1'b1 && rx_conv !== tx_conv) rx_mis <= rx_mis + 1;
      for (int i = 0; i < 2; i++) begin
         if (conv[i] === 1'b1) begin
            gap[i] <= cyc - t_last[i];
            t_last[i] <= cyc;
            cnt[i] <= cnt[i] + 1;
         end
      end
   end

   function automatic logic [8:0] exp_cfg(input logic [15:0] c);
      return {c[11:9], c[7:2]};
   endfunction
   function automatic logic [15:0] sw(input logic [1:0] s, input int t, input int r);
      return {1'b0, 6'(t), 1'b0, 6'(r), s};
   endfunction
   // Period with an adjusted final segment
   function automatic int per(input int a, input int b, input int t);
      int f;
      f = a + t;
      if (f < 0) f = f + 64;
      else if (f < 2) f = a;
      return (b - 1) * a + f;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wait_conv(input int i);
      int c0 = cnt[i];
      for (int k = 0; k < 3000 && cnt[i] == c0; k++) @(negedge clock);
      if (cnt[i] == c0) begin
         err_total++;
         end_sim();
      end
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
   endtask

   initial begin
      void'($urandom(32'h1B2A));
      do_reset();
      @(negedge clock);
      chk(cfg_out, exp_cfg(16'h02E4));
      wait_conv(0);
      wait_conv(0);
      chk(gap[0], per(18, 18, 0));
      chk(rx_mis, 0);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         w = $urandom;
         w[1:0] = 2'h3;
         host.burst(16'h0003, w);
         @(negedge clock);
         chk(cfg_out, exp_cfg(w));
         chk(secondary_expected, 0);
         w = $urandom;
         w[1:0] = 2'h0;
         host.send(w);
         repeat (3) @(negedge clock);
         chk(dac_data, w[15:2]);
      end
      host.burst(16'h0003, 16'h02E7);
      $display("test words done");
      host.burst(16'h0003, sw(2'h0, 8, 8));
      host.burst(16'h0003, sw(2'h2, 15, 15));
      for (int k = 0; k < 4; k++) begin
         host.burst(16'h0003, sw(2'h1, tv[k], tv[k]));
         wait_conv(0);
         wait_conv(0);
         chk(gap[0], per(8, 15, 0));
         host.send(16'(op[k]));
         wait_conv(0);
         chk(gap[0], per(8, 15, op[k] == 2 ? -tv[k] : tv[k]));
         wait_conv(0);
         chk(gap[0], per(8, 15, 0));
      end
      host.burst(16'h0003, 16'h02C7);
      host.burst(16'h0003, sw(2'h0, 8, 10));
      wait_conv(1);
      wait_conv(1);
      chk(gap[1], per(10, 15, 0));
      wait_conv(1);
      host.burst(16'h0003, sw(2'h0, 8, 12));
      host.burst(16'h0003, sw(2'h0, 8, 6));
      wait_conv(1);
      wait_conv(1);
      chk(gap[1], per(12, 15, 0));
      $display("test timing done");
      for (int k = 0; k < 4; k++) begin
         do_reset();
         word_mode <= gm[k];
         host.burst(16'h0003, sw(2'h0, ga[k], 8));
         repeat (3) @(negedge clock);
         chk({shutdown, port_halted}, gx[k]);
         host.send(16'h5554);
         @(negedge clock);
         chk(dac_data, gx[k] != 2'h0 ? 14'h0000 : 14'h1555);
      end
      host.burst(16'h0003, sw(2'h2, 14, 14));
      wait_conv(0);
      wait_conv(0);
      chk(gap[0], per(5, 18, 0));
      $display("test guard done");
      end_sim();
   end
endmodule // tb
`default_nettype wire
